/* flash_boot_pkg.sv */
// constants shared by the serial flash boot sequencer
package flash_boot_pkg;
    // ------------------------------------------------------------
    // flash command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WAKE = 8'hAB;
    localparam logic [7:0] CMD_FAST_READ = 8'h0B;
    localparam logic [7:0] CMD_SLEEP = 8'hB9;
    localparam logic [23:0] BOOT_ADDR = 24'h000000;
    // ------------------------------------------------------------
    // timing and counts
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50000000;
    localparam int WAKE_GAP_US = 10;
    localparam int WAKE_GAP_CYC = (WAKE_GAP_US * CLK_HZ + 999999) / 1000000;
    localparam int DUMMY_BITS = 8;
    localparam int PIN_RELEASE_CYC = 49;
    localparam int MAX_TRIES = 6;
    localparam int VEC_BYTES = 3;
    // image length in bytes used by the default (bytes of payload)
    localparam logic [23:0] IMAGE_BYTES_DEF = 24'h000100;
    // sync word search window in bytes
    localparam logic [23:0] SYNC_WINDOW_DEF = 24'h000010;
    localparam logic [31:0] SYNC_WORD = 32'h7EAA997E;
    // ------------------------------------------------------------
    // register map (wishbone, byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LENGTH = 4'h8;
    localparam logic [3:0] REG_DATA = 4'hC;
    localparam int CTRL_SLEEP_EN = 0;
    localparam int CTRL_COLD_EN = 1;
    localparam int CTRL_REBOOT = 2;
    localparam int CTRL_SEL_LO = 3;
    localparam int CTRL_SEL_HI = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
endpackage : flash_boot_pkg

/* spi_flash_boot_sequencer.sv */
// serial flash configuration loader with cold and warm image selection
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Summary of operation
// - start by selecting flash and sending wake command AB
// - command and address bits change on falling serial clock
// - deselect flash after last bit of wake command
// - wait at least ten microseconds before next select
// - fast read 0B then 24-bit address, msb first
// - first load after reset uses address zero
// - eight dummy clocks before data is taken
// - undriven input line reads as one
// - flash changes data on falling edge, device samples on rising
// - deselect after required image bits received
// - optional sleep command B9 when enabled
// - sample image select pins after reset when cold boot enabled
// - always load address zero first, then check cold boot
// - two-bit select indexes a 24-bit stored start address
// - restart reading from the selected start address
// - initial image holds table of four start addresses
// - release select pins to the application after configuration
// - warm boot choice comes from two application signals
// - reboot request restarts from chosen vector address
// - master loading only when select strap floats high
// - user pins enabled 49 clocks after done
// - read up to six times in all on missing sync, then raise the low power flag
// ------------------------------------------------------------
module spi_flash_boot_sequencer
    import flash_boot_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic config_reset_n_i,
    input wire logic master_strap_i,
    input wire logic image_select_pin_lo_i,
    input wire logic image_select_pin_hi_i,
    input wire logic flash_miso_i,
    output logic flash_sck_o,
    output logic flash_cs_n_o,
    output logic flash_mosi_o,
    output logic slave_mode_o,
    output logic config_done_flag_o,
    output logic user_io_enable_o,
    output logic low_power_o,
    output logic [7:0] data_o,
    output logic data_valid_o,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [9:0] {
        S_IDLE  = 10'b0000000001,
        S_WAKE  = 10'b0000000010,
        S_GAP   = 10'b0000000100,
        S_CMD   = 10'b0000001000,
        S_DUMMY = 10'b0000010000,
        S_DATA  = 10'b0000100000,
        S_END   = 10'b0001000000,
        S_SLEEP = 10'b0010000000,
        S_DONE  = 10'b0100000000,
        S_SLAVE = 10'b1000000000
    } state_e;

    state_e state_reg;
    logic [4:0] ctrl_reg;
    logic [23:0] length_reg;
    logic [31:0] tx_reg;
    logic [5:0] bit_cnt_reg;
    logic [7:0] rx_reg;
    logic [23:0] byte_cnt_reg;
    logic [9:0] gap_cnt_reg;
    logic [23:0] start_reg;
    logic [1:0] vec_sel_reg;
    logic vec_phase_reg;
    logic [23:0] vec_addr_reg;
    logic [31:0] sync_sh_reg;
    logic sync_ok_reg;
    logic [2:0] tries_reg;
    logic [5:0] rel_cnt_reg;
    logic cres_d_reg;
    logic sck_reg;
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes land on the edge at which the master sees ack high
    wire bus_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
    wire wr_ctrl = bus_wr && wb_adr_i == REG_CTRL && wb_sel_i[0];
    wire wr_len = bus_wr && wb_adr_i == REG_LENGTH;
    wire [31:0] rd_mux = (wb_adr_i == REG_CTRL) ? {27'h0, ctrl_reg} :
        (wb_adr_i == REG_STATUS) ? {16'h0, tries_reg, 1'b0, low_power_o,
            user_io_enable_o, config_done_flag_o, slave_mode_o, 8'h0} :
        (wb_adr_i == REG_LENGTH) ? {8'h0, length_reg} :
        (wb_adr_i == REG_DATA) ? {24'h0, rx_reg} : 32'h0;
    // config reset low holds the sequencer idle; rising edge starts it
    wire cres_rise = config_reset_n_i && !cres_d_reg;
    // serial engine: sck_reg high means rising edge was just issued
    wire fall_edge = sck_reg;
    wire rise_edge = !sck_reg;
    wire shifting = (state_reg == S_WAKE) || (state_reg == S_CMD) ||
        (state_reg == S_DUMMY) || (state_reg == S_DATA) || (state_reg == S_SLEEP);
    wire sample_bit = flash_miso_i; // pull-up makes idle line read one
    wire [7:0] byte_in = {rx_reg[6:0], sample_bit};
    wire byte_done = rise_edge && bit_cnt_reg == 6'd7;
    wire cold_sel_ok = ctrl_reg[CTRL_COLD_EN];
    wire reboot = ctrl_reg[CTRL_REBOOT];
    wire [1:0] warm_sel = {ctrl_reg[CTRL_SEL_HI], ctrl_reg[CTRL_SEL_LO]};
    wire table_end = vec_phase_reg && byte_cnt_reg == 24'd12;

    // ------------------------------------------------------------
    // bus slave, one registered ack per request, a cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl_reg <= CTRL_RESET;
            length_reg <= IMAGE_BYTES_DEF;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_mux : wb_dat_o;
            if (wr_ctrl) begin
                ctrl_reg <= wb_dat_i[4:0];
            end else if (reboot && state_reg == S_DONE) begin
                ctrl_reg[CTRL_REBOOT] <= 1'b0;
            end
            if (wr_len) begin
                length_reg <= wb_dat_i[23:0];
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= S_IDLE;
            flash_cs_n_o <= 1'b1;
            flash_sck_o <= 1'b0;
            sck_reg <= 1'b0;
            flash_mosi_o <= 1'b0;
            tx_reg <= 32'h0;
            bit_cnt_reg <= 6'd0;
            rx_reg <= 8'h0;
            byte_cnt_reg <= 24'h0;
            gap_cnt_reg <= 10'd0;
            start_reg <= BOOT_ADDR;
            vec_sel_reg <= 2'b00;
            vec_phase_reg <= 1'b0;
            vec_addr_reg <= 24'h0;
            sync_sh_reg <= 32'h0;
            sync_ok_reg <= 1'b0;
            tries_reg <= 3'd0;
            rel_cnt_reg <= 6'd0;
            cres_d_reg <= 1'b0;
            slave_mode_o <= 1'b0;
            config_done_flag_o <= 1'b0;
            user_io_enable_o <= 1'b0;
            low_power_o <= 1'b0;
            data_o <= 8'h0;
            data_valid_o <= 1'b0;
        end else begin
            cres_d_reg <= config_reset_n_i;
            data_valid_o <= 1'b0;
            if (shifting) begin
                sck_reg <= !sck_reg;
                flash_sck_o <= !sck_reg;
            end else begin
                sck_reg <= 1'b0;
                flash_sck_o <= 1'b0;
            end
            if (!config_reset_n_i) begin
                state_reg <= S_IDLE;
                flash_cs_n_o <= 1'b1;
                config_done_flag_o <= 1'b0;
                user_io_enable_o <= 1'b0;
                tries_reg <= 3'd0;
                slave_mode_o <= 1'b0;
                low_power_o <= 1'b0;
                start_reg <= BOOT_ADDR;
            end else begin
                case (state_reg)
                    S_IDLE: begin
                        if (cres_rise) begin
                            if (!master_strap_i) begin
                                state_reg <= S_SLAVE;
                                slave_mode_o <= 1'b1;
                            end else begin
                                // image select pins sampled at start
                                vec_sel_reg <= {image_select_pin_hi_i,
                                    image_select_pin_lo_i};
                                start_reg <= BOOT_ADDR;
                                vec_phase_reg <= cold_sel_ok;
                                flash_cs_n_o <= 1'b0;
                                tx_reg <= {CMD_WAKE, 24'h0};
                                flash_mosi_o <= CMD_WAKE[7];
                                bit_cnt_reg <= 6'd0;
                                state_reg <= S_WAKE;
                            end
                        end
                    end
                    S_WAKE: begin
                        if (fall_edge) begin
                            if (bit_cnt_reg == 6'd7) begin
                                flash_cs_n_o <= 1'b1;
                                gap_cnt_reg <= 10'd0;
                                state_reg <= S_GAP;
                            end else begin
                                tx_reg <= {tx_reg[30:0], 1'b0};
                                flash_mosi_o <= tx_reg[30];
                                bit_cnt_reg <= bit_cnt_reg + 6'd1;
                            end
                        end
                    end
                    S_GAP: begin
                        // wait before the read command
                        if (gap_cnt_reg == 10'(WAKE_GAP_CYC - 1)) begin
                            flash_cs_n_o <= 1'b0;
                            tx_reg <= {CMD_FAST_READ, start_reg};
                            flash_mosi_o <= CMD_FAST_READ[7];
                            bit_cnt_reg <= 6'd0;
                            state_reg <= S_CMD;
                        end else begin
                            gap_cnt_reg <= gap_cnt_reg + 10'd1;
                        end
                    end
                    S_CMD: begin
                        if (fall_edge) begin
                            tx_reg <= {tx_reg[30:0], 1'b0};
                            flash_mosi_o <= tx_reg[30];
                            if (bit_cnt_reg == 6'd31) begin
                                bit_cnt_reg <= 6'd0;
                                state_reg <= S_DUMMY;
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg + 6'd1;
                            end
                        end
                    end
                    S_DUMMY: begin
                        if (fall_edge) begin
                            if (bit_cnt_reg == 6'(DUMMY_BITS - 1)) begin
                                bit_cnt_reg <= 6'd0;
                                byte_cnt_reg <= 24'h0;
                                sync_sh_reg <= 32'h0;
                                sync_ok_reg <= 1'b0;
                                state_reg <= S_DATA;
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg + 6'd1;
                            end
                        end
                    end
                    S_DATA: begin
                        if (rise_edge) begin
                            rx_reg <= byte_in; // sample on rising edge
                            bit_cnt_reg <= (bit_cnt_reg == 6'd7) ? 6'd0 : bit_cnt_reg + 6'd1;
                        end
                        if (byte_done) begin
                            // bytes arrive msb first
                            byte_cnt_reg <= byte_cnt_reg + 24'd1;
                            sync_sh_reg <= {sync_sh_reg[23:0], byte_in};
                            if ({sync_sh_reg[23:0], byte_in} == SYNC_WORD) begin
                                sync_ok_reg <= 1'b1;
                            end
                            data_o <= byte_in;
                            data_valid_o <= !vec_phase_reg;
                            // vector table: four 24-bit entries
                            if (vec_phase_reg &&
                                byte_cnt_reg >= 24'(vec_sel_reg) * 24'd3 &&
                                byte_cnt_reg < 24'(vec_sel_reg) * 24'd3 + 24'(VEC_BYTES)) begin
                                vec_addr_reg <= {vec_addr_reg[15:0], byte_in};
                            end
                        end
                        if (fall_edge && !sync_ok_reg &&
                            byte_cnt_reg == SYNC_WINDOW_DEF && !vec_phase_reg) begin
                            flash_cs_n_o <= 1'b1;
                            state_reg <= S_END;
                        end else if (fall_edge && table_end) begin
                            flash_cs_n_o <= 1'b1;
                            state_reg <= S_END;
                        end else if (fall_edge && byte_cnt_reg == length_reg) begin
                            flash_cs_n_o <= 1'b1;
                            state_reg <= S_END;
                        end
                    end
                    S_END: begin
                        if (vec_phase_reg) begin
                            // restart at the selected image
                            vec_phase_reg <= 1'b0;
                            start_reg <= vec_addr_reg;
                            gap_cnt_reg <= 10'd0;
                            state_reg <= S_GAP;
                        end else if (!sync_ok_reg) begin
                            if (tries_reg == 3'(MAX_TRIES - 1)) begin
                                low_power_o <= 1'b1;
                                state_reg <= S_DONE;
                            end else begin
                                tries_reg <= tries_reg + 3'd1;
                                gap_cnt_reg <= 10'd0;
                                state_reg <= S_GAP;
                            end
                        end else if (ctrl_reg[CTRL_SLEEP_EN]) begin
                            flash_cs_n_o <= 1'b0;
                            tx_reg <= {CMD_SLEEP, 24'h0};
                            flash_mosi_o <= CMD_SLEEP[7];
                            bit_cnt_reg <= 6'd0;
                            state_reg <= S_SLEEP;
                        end else begin
                            config_done_flag_o <= 1'b1;
                            rel_cnt_reg <= 6'd0;
                            state_reg <= S_DONE;
                        end
                    end
                    S_SLEEP: begin
                        if (fall_edge) begin
                            if (bit_cnt_reg == 6'd7) begin
                                flash_cs_n_o <= 1'b1; // flash sleeps now
                                config_done_flag_o <= 1'b1;
                                rel_cnt_reg <= 6'd0;
                                state_reg <= S_DONE;
                            end else begin
                                tx_reg <= {tx_reg[30:0], 1'b0};
                                flash_mosi_o <= tx_reg[30];
                                bit_cnt_reg <= bit_cnt_reg + 6'd1;
                            end
                        end
                    end
                    S_DONE: begin
                        // pins handed over after a fixed delay
                        if (config_done_flag_o && !user_io_enable_o) begin
                            if (rel_cnt_reg == 6'(PIN_RELEASE_CYC - 1)) begin
                                user_io_enable_o <= 1'b1;
                            end else begin
                                rel_cnt_reg <= rel_cnt_reg + 6'd1;
                            end
                        end
                        if (reboot && config_done_flag_o) begin
                            // warm boot uses application select
                            vec_sel_reg <= warm_sel;
                            vec_phase_reg <= 1'b1;
                            start_reg <= BOOT_ADDR;
                            config_done_flag_o <= 1'b0;
                            user_io_enable_o <= 1'b0;
                            tries_reg <= 3'd0;
                            flash_cs_n_o <= 1'b0;
                            tx_reg <= {CMD_WAKE, 24'h0};
                            flash_mosi_o <= CMD_WAKE[7];
                            bit_cnt_reg <= 6'd0;
                            state_reg <= S_WAKE;
                        end
                    end
                    S_SLAVE: begin
                        flash_cs_n_o <= 1'b1;
                    end
                    default: begin
                        state_reg <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wake_go; state_reg == S_IDLE && cres_rise && master_strap_i; endsequence
    sequence s_wake_last; state_reg == S_WAKE && fall_edge && bit_cnt_reg == 6'd7; endsequence
    property p_wake_go; s_wake_go |=> !flash_cs_n_o && state_reg == S_WAKE; endproperty
    a_wake_go: assert property (p_wake_go) else $error("wake not started");
    property p_wake_end; s_wake_last |=> flash_cs_n_o; endproperty
    a_wake_end: assert property (p_wake_end) else $error("select held after wake");
    property p_gap_cs; state_reg == S_GAP |-> flash_cs_n_o && !flash_sck_o; endproperty
    a_gap_cs: assert property (p_gap_cs) else $error("select low in gap");
    property p_mosi_hold; shifting && !flash_sck_o |=> $stable(flash_mosi_o); endproperty
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved on rise");
    property p_dummy; $rose(state_reg == S_DATA) |-> $past(bit_cnt_reg) == 6'd7; endproperty
    a_dummy: assert property (p_dummy) else $error("dummy count off");
    property p_end_cs; state_reg == S_END |-> flash_cs_n_o; endproperty
    a_end_cs: assert property (p_end_cs) else $error("select low after read");
    property p_slave; state_reg == S_SLAVE |-> flash_cs_n_o && !flash_sck_o; endproperty
    a_slave: assert property (p_slave) else $error("flash driven in slave mode");
endmodule : spi_flash_boot_sequencer
`default_nettype wire

/* flash_model.sv */
// behavioural serial flash: wake, fast read, deep power-down
`timescale 1ns/1ps
`default_nettype none
module flash_model
    import flash_boot_pkg::*;
(
    input wire logic clk_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] cmds [$];
    logic [23:0] addrs [$];
    logic [31:0] sh = 32'h0;
    logic [7:0] cur = 8'h00;
    logic [7:0] last_byte = 8'h00;
    logic asleep = 1'b0;
    int bits = 0, nbytes = 0, gap = 0, gap_min = 0, k;
    initial miso_o = 1'b1;
    // command, address and image bits all land as sck rises
    always @(posedge sck_i) begin
        if (!cs_n_i) begin
            sh = {sh[30:0], mosi_i};
            bits = bits + 1;
            if (bits == 8 && (!asleep || sh[7:0] == CMD_WAKE)) begin
                cur = sh[7:0];
                cmds.push_back(cur);
                if (cur == CMD_FAST_READ) nbytes = 0;
            end
            if (bits == 32 && cur == CMD_FAST_READ) addrs.push_back(sh[23:0]);
            if (cur == CMD_FAST_READ && bits > 40 && (bits - 40) % 8 == 0) begin
                last_byte = mem[16'(addrs[$] + 24'((bits - 41) / 8))];
                nbytes = nbytes + 1;
            end
        end
    end
    // data moves on the falling edge; an idle line floats high
    always @(negedge sck_i) begin
        k = bits - 40;
        if (!cs_n_i && cur == CMD_FAST_READ && k >= 0) miso_o = mem[16'(addrs[$] + 24'(k / 8))][7 - k % 8];
        else miso_o = 1'b1;
    end
    // deselect ends a command; a sleeping part ignores all but wake
    always @(posedge cs_n_i) begin
        miso_o = 1'b1;
        if (cur == CMD_SLEEP) asleep = 1'b1;
        if (cur == CMD_WAKE) asleep = 1'b0;
        gap = 0;
    end
    always @(negedge cs_n_i) begin
        if (cur == CMD_WAKE && (gap_min == 0 || gap < gap_min)) gap_min = gap;
        bits = 0;
        cur = 8'h00;
    end
    always @(posedge clk_i) if (cs_n_i) gap = gap + 1;
endmodule // flash_model
`default_nettype wire

/* spi_flash_boot_sequencer_tb.sv */
// self-checking bench for the flash boot sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module spi_flash_boot_sequencer_tb;
    import flash_boot_pkg::*;
    localparam logic [23:0] LEN = 24'h000020;
    logic clk_i = 0, rst_i = 1, cfg_n = 0, strap = 1, sel_lo = 0, sel_hi = 0;
    logic miso, sck, cs_n, mosi, slave, done, uio, lowp, dvalid, ack, puio, pm, pk, pc;
    logic we = 0, cyc = 0, stb = 0, cold, slp;
    logic [7:0] data;
    logic [3:0] adr = 4'h0, bsel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic [23:0] entry [0:3];
    logic [1:0] csel;
    int mismatches = 0, n_checks = 0, seed = 83819, dcnt = 0, uio_gap = 0, t;
    always #10 clk_i = ~clk_i;
    spi_flash_boot_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .config_reset_n_i(cfg_n),
        .master_strap_i(strap), .image_select_pin_lo_i(sel_lo), .image_select_pin_hi_i(sel_hi),
        .flash_miso_i(miso), .flash_sck_o(sck), .flash_cs_n_o(cs_n), .flash_mosi_o(mosi),
        .slave_mode_o(slave), .config_done_flag_o(done), .user_io_enable_o(uio),
        .low_power_o(lowp), .data_o(data), .data_valid_o(dvalid), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(bsel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack));
    flash_model fm (.clk_i(clk_i), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso));
    // -----------------------------------------------------------
    // monitors
    // -----------------------------------------------------------
    always @(posedge clk_i) begin
        if (dvalid === 1'b1) `CHK("image byte", fm.last_byte, data)
        dcnt <= (done === 1'b1) ? dcnt + 1 : 0;
        if (uio === 1'b1 && puio !== 1'b1) uio_gap <= dcnt;
        puio <= uio;
    end
    // mosi may only move together with a falling sck inside a frame
    always @(negedge clk_i) begin
        if (cs_n === 1'b0 && pc === 1'b0 && mosi !== pm && !(pk && !sck)) `CHK("mosi edge", pm, mosi)
        pm = mosi;
        pk = sck;
        pc = cs_n;
    end
    // -----------------------------------------------------------
    // tasks
    // -----------------------------------------------------------
    task automatic wb_rw(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat, bsel} <= {1'b1, 1'b1, w, a, d, 4'hF};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        r = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    // clears the flash log; go also pulses the config reset
    task automatic start(input logic go);
        fm.cmds.delete();
        fm.addrs.delete();
        fm.gap_min = 0;
        uio_gap = 0;
        @(posedge clk_i);
        cfg_n <= !go;
        repeat (2) @(posedge clk_i);
        cfg_n <= 1'b1;
    endtask
    // a load is over once the final read delivered every byte
    task automatic wait_load();
        t = 0;
        while (!(fm.addrs.size() > 0 && cs_n === 1'b1 && done === 1'b1 && fm.nbytes == LEN) && t < 40000) begin
            @(posedge clk_i);
            t++;
        end
        `CHK("load end", 1'b1, t < 40000)
        repeat (60) @(posedge clk_i);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        stop_test();
    end
    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial begin
        for (int i = 0; i < 32; i++) fm.mem[i] = 8'($random(seed));
        for (int i = 0; i < 4; i++) begin
            entry[i] = {8'h00, 2'(i), 6'($random(seed)) | 6'h01, 8'h00};
            for (int b = 0; b < 3; b++) fm.mem[i * 3 + b] = entry[i][23 - 8 * b -: 8];
            for (int b = 0; b < 32; b++) fm.mem[entry[i][15:0] + 16'(b)] = (b < 4) ? SYNC_WORD[31 - 8 * b -: 8] : 8'($random(seed));
        end
        for (int b = 0; b < 4; b++) fm.mem[12 + b] = SYNC_WORD[31 - 8 * b -: 8];
        repeat (2) @(posedge clk_i);
        `CHK("cs_n in reset", 1'b1, cs_n)
        `CHK("sck in reset", 1'b0, sck)
        rst_i <= 1'b0;
        wb_rw(1'b0, REG_CTRL, 32'h0, rd);
        `CHK("ctrl reset", CTRL_RESET, rd[4:0])
        strap <= 1'b0;
        start(1'b1);
        repeat (20) @(posedge clk_i);
        `CHK("slave mode", 1'b1, slave)
        `CHK("slave quiet", 0, fm.cmds.size())
        strap <= 1'b1;
        wb_rw(1'b1, REG_LENGTH, {8'h00, LEN}, rd);
        wb_rw(1'b0, REG_LENGTH, 32'h0, rd);
        `CHK("length", LEN, rd[23:0])
        // first load cold with image 3, second puts the flash to sleep
        for (int n = 0; n < 6; n++) begin
            cold = (n == 0) ? 1'b1 : 1'($random(seed));
            slp = (n == 1) ? 1'b1 : 1'($random(seed));
            csel = (n == 0) ? 2'h3 : 2'($random(seed));
            wb_rw(1'b1, REG_CTRL, {30'h0, cold, slp}, rd);
            {sel_hi, sel_lo} <= csel;
            start(1'b1);
            wait_load();
            `CHK("wake cmd", CMD_WAKE, fm.cmds[0])
            `CHK("read cmd", CMD_FAST_READ, fm.cmds[1])
            `CHK("wake gap", 1'b1, fm.gap_min >= WAKE_GAP_CYC)
            `CHK("first addr", BOOT_ADDR, fm.addrs[0])
            `CHK("read count", cold ? 2 : 1, fm.addrs.size())
            if (cold) `CHK("cold addr", entry[csel], fm.addrs[1])
            `CHK("sleep cmd", slp, fm.cmds[$] == CMD_SLEEP)
            `CHK("pin delay", 49, uio_gap)
        end
        csel = 2'($random(seed));
        start(1'b0);
        wb_rw(1'b1, REG_CTRL, {27'h0, csel, 3'b100}, rd);
        wait_load();
        `CHK("warm addr", entry[csel], fm.addrs[$])
        wb_rw(1'b0, REG_CTRL, 32'h0, rd);
        `CHK("reboot clear", 1'b0, rd[CTRL_REBOOT])
        // no sync word anywhere at address zero
        for (int i = 0; i < 32; i++) fm.mem[i] = 8'h00;
        wb_rw(1'b1, REG_CTRL, 32'h0, rd);
        start(1'b1);
        t = 0;
        while (lowp !== 1'b1 && t < 40000) begin
            @(posedge clk_i);
            t++;
        end
        `CHK("low power", 1'b1, lowp)
        `CHK("retries", 1'b1, fm.addrs.size() >= MAX_TRIES)
        `CHK("not done", 1'b0, done)
        stop_test();
    end
endmodule // spi_flash_boot_sequencer_tb
`default_nettype wire
